// [verilog/mcf_pkg.sv]
/*
  Shared constants, state encodings and the check-sequence function of the
  management channel framer.
  Assumes a single clock domain; line-frame strobes come from same-clock logic.
*/
package mcf_pkg;

  // Octet values
  localparam logic [7:0] SYNC = 8'h7E;
  localparam logic [7:0] ESC = 8'h7D;
  localparam logic [7:0] ESC_XOR = 8'h20;
  localparam logic [7:0] ESC_SYNC = 8'h5E;
  localparam logic [7:0] ESC_ESC = 8'h5D;

  // Line mapping: 20 channel bits a line frame, 5 octets per frame pair
  localparam logic [4:0] CH_BITS = 5'h14;
  localparam logic [2:0] GRP_OCTETS = 3'h5;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Frame limits, 75 octets at most, addr + id + 2 check octets at least
  localparam logic [6:0] MAX_FRAME = 7'h4B;
  localparam logic [6:0] MIN_FRAME = 7'h04;
  localparam logic [6:0] FCS_OCTETS = 7'h02;
  localparam logic [6:0] ID_INDEX = 7'h01;
  localparam logic [6:0] ADDR_INDEX = 7'h00;
  localparam logic [2:0] PROBE_SYNCS = 3'h5;
  localparam logic [2:0] GAP_SYNCS = 3'h1;

  // Check sequence
  localparam logic [15:0] FCS_INIT = 16'hFFFF;
  localparam logic [15:0] FCS_POLY_REV = 16'h8408;
  localparam logic [15:0] FCS_GOOD = 16'hF0B8;

  // Addresses
  localparam logic [3:0] ADDR_NEIGHBOUR = 4'h0;
  localparam logic [3:0] ADDR_BCAST = 4'hF;
  localparam logic [3:0] ADDR_BAD_LO = 4'hD;
  localparam logic [3:0] ADDR_BAD_HI = 4'hE;

  // Message identifier ranges
  localparam logic [7:0] ID_PROBE = 8'h01;
  localparam logic [7:0] ID_REQ_LAST = 8'h40;
  localparam logic [7:0] ID_RSP_FIRST = 8'h80;
  localparam logic [7:0] ID_RSP_LAST = 8'hC0;

  localparam int FIFO_DEPTH = 8;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_ADDR = 5'h02,
    TX_BODY = 5'h04,
    TX_FCS_LO = 5'h08,
    TX_FCS_HI = 5'h10
  } mcf_tx_state_t;

  // Reflected CRC, one octet, least significant bit first
  function automatic logic [15:0] mcf_fcs_byte(logic [15:0] f, logic [7:0] b);
    logic [15:0] c;
    c = f;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ b[i]) begin
        c = (c >> 1) ^ FCS_POLY_REV;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

endpackage

// [verilog/mcf_framer.sv]
/*
  Management channel framer: message FIFO, transmit framer with stuffing and
  check sequence, line-bit mapper, receive aligner and deframer with buffer.
  Assumes line strobes at least 24 clocks apart and a message source that
  delivers a started message without gaps.
*/
// Behaviour
// - Channel uses bits 1 to 20 per line frame; two frames carry five octets.
// - Octets start at bits 1,9,17 then 5,13; each sent LSB first.
// - Receiver finds octet alignment by hunting the 7E sync pattern.
// - With dual-loop active, identical copies go out on both loops.
// - Numeric fields travel most significant octet first, LSB first within.
// - Fixed strings, first character first, space padded or null ended.
// - Channel is a plain octet stream; messages are whole octets.
// - First octet: destination low nibble, source high nibble; no control.
// - At least one sync between frames; idle time filled with syncs.
// - Discovery probe frames follow at least five sync octets.
// - Frame at most 75 octets, excluding syncs and escape octets.
// - Information field holds one message, identifier octet first.
// - Transmit 7E as 7D,5E and 7D as 7D,5D.
// - Receive 7D,5E as 7E, 7D,5D as 7D; other escape pairs abort.
// - Check sequence covers unstuffed content, appended as two octets.
// - Check sequence bits sent reversed, low octet first.
// - Separate source and destination addresses per upstream and downstream.
// - Address F is broadcast destination only, never a source.
// - Destination 0 means the directly attached neighbour.
// - Address 1 office end, 2 remote end, 3-A regenerators; D,E barred.
// - Identifiers 0-64 requests, 128-192 responses.

module mcf_fifo #(
  parameter int W = 9,
  parameter int D = mcf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } mcf_fifo_state_t;

  mcf_fifo_state_t q;
  mcf_fifo_state_t d;
  logic push;
  logic pop;

  always_comb begin
    d = q;
    push = in_valid && q.rdy;
    pop = out_ready && (q.cnt != '0);
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // Registered ready keeps the fill side free of a combinational path
    d.rdy = d.cnt != (AW + 1)'(D);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready = q.rdy;
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
endmodule // mcf_fifo

module mcf_framer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Unit addresses and line options
  input wire logic line_side,
  input wire logic [3:0] up_src,
  input wire logic [3:0] up_dst,
  input wire logic [3:0] dn_src,
  input wire logic [3:0] dn_dst,
  input wire logic dual_loop_en,
  // Outgoing message octets
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // Line transmit
  input wire logic line_tx_req,
  output logic [19:0] tx_bits_a,
  output logic [19:0] tx_bits_b,
  // Line receive
  input wire logic line_rx_valid,
  input wire logic [19:0] rx_bits,
  // Incoming message octets
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic rx_ready,
  output logic [3:0] rx_src,
  output logic [3:0] rx_dst,
  output logic rx_for_unit,
  output logic rx_bcast,
  output logic rx_is_req,
  output logic rx_is_rsp,
  output logic rx_frame_err,
  output logic rx_locked
);
  typedef struct packed {
    mcf_pkg::mcf_tx_state_t st;
    logic [2:0] syncs;
    logic [6:0] tlen;
    logic [15:0] tfcs;
    logic esc_pend;
    logic [7:0] esc_oct;
    logic drain;
    logic [3:0] tsrc;
    logic [3:0] tdst;
    logic [4:0][7:0] grp;
    logic [2:0] fill;
    logic [39:0] sh;
    logic phase;
    logic [19:0] bits_a;
    logic [19:0] bits_b;
    logic [19:0] sr;
    logic [4:0] nb;
    logic [7:0] win;
    logic locked;
    logic [2:0] bc;
    logic inf;
    logic esc;
    logic bad;
    logic [6:0] len;
    logic [15:0] fcs;
    logic [74:0][7:0] mem;
    logic busy;
    logic [6:0] rd;
    logic [6:0] last_idx;
    logic rv;
    logic [7:0] rdat;
    logic rlast;
    logic [3:0] rsrc;
    logic [3:0] rdst;
    logic for_unit;
    logic bcast;
    logic is_req;
    logic is_rsp;
    logic err;
  } mcf_state_t;

  function automatic logic addr_allowed(logic [3:0] a);
    return !(a == mcf_pkg::ADDR_BAD_LO || a == mcf_pkg::ADDR_BAD_HI);
  endfunction

  mcf_state_t q;
  mcf_state_t d;
  logic f_valid;
  logic [8:0] f_word;
  logic f_pop;
  logic [7:0] o;
  logic [7:0] raw;
  logic emit;
  logic stuff;
  logic ev;
  logic [7:0] win_n;
  logic [7:0] dec;
  logic good;
  logic [3:0] own;

  mcf_fifo #(.W(9), .D(mcf_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(tx_valid),
    .in_data({tx_last, tx_data}),
    .in_ready(tx_ready),
    .out_valid(f_valid),
    .out_data(f_word),
    .out_ready(f_pop)
  );

  always_comb begin
    d = q;
    f_pop = 1'b0;
    o = mcf_pkg::SYNC;
    raw = mcf_pkg::SYNC;
    emit = 1'b0;
    stuff = 1'b0;
    ev = 1'b0;
    win_n = q.win;
    dec = q.win;
    good = 1'b0;
    own = line_side ? dn_src : up_src;
    d.err = 1'b0;

    // Transmit: one octet into the line group per clock while room remains and no truncated message is being drained
    if (q.drain && f_valid) begin
      f_pop = 1'b1;
      d.drain = !f_word[8];
    end else if (q.fill < mcf_pkg::GRP_OCTETS) begin
      emit = 1'b1;
      if (q.esc_pend) begin
        o = q.esc_oct ^ mcf_pkg::ESC_XOR;
        d.esc_pend = 1'b0;
      end else begin
        case (q.st)
          mcf_pkg::TX_IDLE: begin
            o = mcf_pkg::SYNC;
            if (q.syncs < mcf_pkg::PROBE_SYNCS) begin
              d.syncs = q.syncs + 3'h1;
            end
            if (f_valid && !q.drain && (q.syncs >= ((f_word[7:0] ==
                mcf_pkg::ID_PROBE) ? mcf_pkg::PROBE_SYNCS :
                mcf_pkg::GAP_SYNCS))) begin
              d.st = mcf_pkg::TX_ADDR;
              d.tfcs = mcf_pkg::FCS_INIT;
              d.tlen = 7'h01;
              d.tsrc = line_side ? dn_src : up_src;
              d.tdst = line_side ? dn_dst : up_dst;
              if (d.tsrc == mcf_pkg::ADDR_BCAST) begin
                d.tsrc = mcf_pkg::ADDR_NEIGHBOUR;
              end
            end
          end
          mcf_pkg::TX_ADDR: begin
            raw = {q.tsrc, q.tdst};
            stuff = 1'b1;
            d.tfcs = mcf_pkg::mcf_fcs_byte(q.tfcs, raw);
            d.st = mcf_pkg::TX_BODY;
          end
          mcf_pkg::TX_BODY: begin
            // identifier then content, passed in order
            raw = f_word[7:0];
            stuff = f_valid;
            emit = f_valid;
            f_pop = f_valid;
            if (f_valid) begin
              d.tfcs = mcf_pkg::mcf_fcs_byte(q.tfcs, raw);
              d.tlen = q.tlen + 7'h01;
              if (f_word[8] ||
                  d.tlen == mcf_pkg::MAX_FRAME - mcf_pkg::FCS_OCTETS) begin
                d.st = mcf_pkg::TX_FCS_LO;
                d.drain = !f_word[8];
              end
            end
          end
          mcf_pkg::TX_FCS_LO: begin
            raw = ~q.tfcs[7:0];
            stuff = 1'b1;
            d.st = mcf_pkg::TX_FCS_HI;
          end
          mcf_pkg::TX_FCS_HI: begin
            raw = ~q.tfcs[15:8];
            stuff = 1'b1;
            d.st = mcf_pkg::TX_IDLE;
            d.syncs = '0;
          end
          default: begin
            d.st = mcf_pkg::TX_IDLE;
          end
        endcase
        if (stuff) begin
          if (raw == mcf_pkg::SYNC || raw == mcf_pkg::ESC) begin
            o = mcf_pkg::ESC;
            d.esc_pend = 1'b1;
            d.esc_oct = raw;
          end else begin
            o = raw;
          end
        end
      end
      if (emit) begin
        d.grp[q.fill] = o;
        d.fill = q.fill + 3'h1;
      end
    end

    // five octets over two line frames
    if (line_tx_req) begin
      if (!q.phase) begin
        // An unfinished group is replaced by syncs to keep alignment
        d.sh = (q.fill == mcf_pkg::GRP_OCTETS) ? q.grp : {5{mcf_pkg::SYNC}};
        if (q.fill == mcf_pkg::GRP_OCTETS) begin
          d.fill = '0;
        end
        // octet boundaries at bits 1, 9, 17 then 5, 13
        d.bits_a = d.sh[19:0];
      end else begin
        d.bits_a = q.sh[39:20];
      end
      d.phase = !q.phase;
      d.bits_b = dual_loop_en ? d.bits_a : '0;
    end

    // Receive bit engine, LSB first into the octet window
    if (q.nb != '0) begin
      win_n = {q.sr[0], q.win[7:1]};
      d.win = win_n;
      d.sr = q.sr >> 1;
      d.nb = q.nb - 5'h01;
      if (!q.locked) begin
        if (win_n == mcf_pkg::SYNC) begin
          d.locked = 1'b1;
          d.bc = '0;
          ev = 1'b1;
        end
      end else if (q.bc == mcf_pkg::BIT_LAST) begin
        d.bc = '0;
        ev = 1'b1;
      end else begin
        d.bc = q.bc + 3'h1;
      end
    end
    if (line_rx_valid) begin
      d.sr = rx_bits;
      d.nb = mcf_pkg::CH_BITS;
    end

    // Receive deframer
    if (ev) begin
      if (win_n == mcf_pkg::SYNC) begin
        if (q.inf && q.len != '0) begin
          good = !q.bad && q.len >= mcf_pkg::MIN_FRAME &&
                 q.fcs == mcf_pkg::FCS_GOOD &&
                 q.mem[mcf_pkg::ADDR_INDEX][7:4] != mcf_pkg::ADDR_BCAST &&
                 addr_allowed(q.mem[mcf_pkg::ADDR_INDEX][7:4]) &&
                 addr_allowed(q.mem[mcf_pkg::ADDR_INDEX][3:0]);
          if (good && !q.busy) begin
            d.busy = 1'b1;
            d.rd = mcf_pkg::ID_INDEX;
            d.last_idx = q.len - mcf_pkg::FCS_OCTETS - 7'h01;
            d.rsrc = q.mem[mcf_pkg::ADDR_INDEX][7:4];
            d.rdst = q.mem[mcf_pkg::ADDR_INDEX][3:0];
            d.for_unit = d.rdst == mcf_pkg::ADDR_NEIGHBOUR ||
                         d.rdst == own || d.rdst == mcf_pkg::ADDR_BCAST;
            d.bcast = d.rdst == mcf_pkg::ADDR_BCAST;
            d.is_req = q.mem[mcf_pkg::ID_INDEX] <= mcf_pkg::ID_REQ_LAST;
            d.is_rsp = q.mem[mcf_pkg::ID_INDEX] >= mcf_pkg::ID_RSP_FIRST &&
                       q.mem[mcf_pkg::ID_INDEX] <= mcf_pkg::ID_RSP_LAST;
          end else begin
            d.err = 1'b1;
          end
        end
        d.inf = 1'b1;
        d.len = '0;
        d.fcs = mcf_pkg::FCS_INIT;
        d.bad = 1'b0;
        d.esc = 1'b0;
      end else if (q.inf) begin
        if (win_n == mcf_pkg::ESC && !q.esc) begin
          d.esc = 1'b1;
        end else if (q.esc && win_n != mcf_pkg::ESC_SYNC &&
                     win_n != mcf_pkg::ESC_ESC) begin
          d.inf = 1'b0;
          d.esc = 1'b0;
          d.locked = 1'b0;
          d.err = 1'b1;
        end else begin
          dec = q.esc ? (win_n ^ mcf_pkg::ESC_XOR) : win_n;
          d.esc = 1'b0;
          d.fcs = mcf_pkg::mcf_fcs_byte(q.fcs, dec);
          if (q.len == mcf_pkg::MAX_FRAME) begin
            d.bad = 1'b1;
          end else if (!q.busy || q.rd > q.len) begin
            d.mem[q.len] = dec;
            d.len = q.len + 7'h01;
          end else begin
            // Readout still owns this slot, so the new frame is lost
            d.bad = 1'b1;
          end
        end
      end
    end

    // Readout of a checked frame, address and check octets removed
    if (q.busy && (!q.rv || rx_ready)) begin
      d.rv = 1'b1;
      d.rdat = q.mem[q.rd];
      d.rlast = q.rd == q.last_idx;
      d.rd = q.rd + 7'h01;
      d.busy = q.rd != q.last_idx;
    end else if (q.rv && rx_ready) begin
      d.rv = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.st <= mcf_pkg::TX_IDLE;
    end else begin
      q <= d;
    end
  end

  assign tx_bits_a = q.bits_a;
  assign tx_bits_b = q.bits_b;
  assign rx_valid = q.rv;
  assign rx_data = q.rdat;
  assign rx_last = q.rlast;
  assign rx_src = q.rsrc;
  assign rx_dst = q.rdst;
  assign rx_for_unit = q.for_unit;
  assign rx_bcast = q.bcast;
  assign rx_is_req = q.is_req;
  assign rx_is_rsp = q.is_rsp;
  assign rx_frame_err = q.err;
  assign rx_locked = q.locked;
endmodule // mcf_framer

// [tb/mcf_framer_props.sv]
/*
  Port checker of the management channel framer.
  Assumes one clock domain; bound to every mcf_framer instance.
*/
module mcf_framer_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Configuration
  input wire logic line_side,
  input wire logic [3:0] up_src,
  input wire logic [3:0] dn_src,
  input wire logic dual_loop_en,
  // Line transmit
  input wire logic line_tx_req,
  input wire logic [19:0] tx_bits_a,
  input wire logic [19:0] tx_bits_b,
  // Message out
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_ready,
  input wire logic [3:0] rx_src,
  input wire logic [3:0] rx_dst,
  input wire logic rx_for_unit,
  input wire logic rx_bcast,
  input wire logic rx_is_req,
  input wire logic rx_is_rsp,
  input wire logic rx_frame_err
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Marks the identifier octet of each delivered message
  logic first_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      first_q <= 1'b1;
    end else if (rx_valid && rx_ready) begin
      first_q <= rx_last;
    end
  end
  a_dual_copy: assert property (line_tx_req && dual_loop_en |=>
    tx_bits_b == tx_bits_a) else $error("loop b copy differs");
  a_single_loop: assert property (line_tx_req && !dual_loop_en |=>
    tx_bits_b == 20'h0_0000) else $error("loop b not quiet");
  a_bits_hold: assert property (!line_tx_req |=>
    $stable(tx_bits_a) && $stable(tx_bits_b)) else $error("line bits moved");
  a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid &&
    $stable(rx_data) && $stable(rx_last)) else $error("rx octet dropped");
  a_bcast_flag: assert property (rx_valid |->
    rx_bcast == (rx_dst == 4'hF)) else $error("broadcast flag wrong");
  a_unit_match: assert property (rx_valid |-> rx_for_unit ==
    (rx_dst == 4'h0 || rx_dst == 4'hF ||
    rx_dst == (line_side ? dn_src : up_src))) else $error("unit flag wrong");
  a_addr_legal: assert property (rx_valid |-> rx_src != 4'hF &&
    !(rx_src inside {4'hD, 4'hE}) && !(rx_dst inside {4'hD, 4'hE}))
    else $error("barred address delivered");
  a_id_class: assert property (rx_valid && first_q |->
    rx_is_req == (rx_data <= 8'h40) &&
    rx_is_rsp == (rx_data inside {[8'h80:8'hC0]})) else $error("id class");
  a_err_pulse: assert property (rx_frame_err |=> !rx_frame_err)
    else $error("error flag held");
  c_dual: cover property (line_tx_req && dual_loop_en);
  c_msg_end: cover property (rx_valid && rx_ready && rx_last);
  c_bcast: cover property (rx_valid && rx_bcast);
  c_err: cover property (rx_frame_err);
endmodule // mcf_framer_props

bind mcf_framer mcf_framer_props mcf_framer_props_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .line_side(line_side),
  .up_src(up_src), .dn_src(dn_src), .dual_loop_en(dual_loop_en),
  .line_tx_req(line_tx_req), .tx_bits_a(tx_bits_a), .tx_bits_b(tx_bits_b),
  .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
  .rx_ready(rx_ready), .rx_src(rx_src), .rx_dst(rx_dst),
  .rx_for_unit(rx_for_unit), .rx_bcast(rx_bcast), .rx_is_req(rx_is_req),
  .rx_is_rsp(rx_is_rsp), .rx_frame_err(rx_frame_err)
);

// [tb/mcf_peer.sv]
/*
  Peer channel framer across the line: maps queued octets into line frames
  and gathers the unit's line bits back into octets.
  Assumes the bench fills txq with stuffed octets and drains rxq.
*/
module mcf_peer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Line
  output logic line_tx_req,
  output logic line_rx_valid,
  output logic [19:0] rx_bits,
  input wire logic [19:0] tx_bits_a
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic [39:0] tgrp;
  logic [39:0] rgrp;
  bit ph;
  initial begin
    line_tx_req = 1'b0;
    line_rx_valid = 1'b0;
    rx_bits = 20'h0_0000;
    tgrp = '0;
    rgrp = '0;
    ph = 1'b0;
    @(posedge arst_n);
    repeat (3) @(posedge clk_sys);
    forever begin
      #1;
      if (!ph) for (int k = 0; k < 5; k++) begin
        tgrp[8*k+:8] = txq.size() ? txq.pop_front() : 8'h7E;
      end
      rx_bits = ph ? tgrp[39:20] : tgrp[19:0];
      line_tx_req = 1'b1;
      line_rx_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      line_tx_req = 1'b0;
      line_rx_valid = 1'b0;
      // Bits are meaningless outside a strobe, so scramble them
      rx_bits = ~rx_bits;
      @(posedge clk_sys);
      #1;
      if (ph) rgrp[39:20] = tx_bits_a;
      else rgrp[19:0] = tx_bits_a;
      if (ph) for (int k = 0; k < 5; k++) rxq.push_back(rgrp[8*k+:8]);
      ph = !ph;
      repeat (22) @(posedge clk_sys);
    end
  end
endmodule // mcf_peer

// [tb/mcf_framer_test.sv]
/*
  Self-checking bench of the management channel framer.
  Assumes the peer model on the line and a free-running 200 MHz clock.
*/
module mcf_framer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, arst_n, line_side, dual_loop_en, tx_valid, tx_last;
  logic [3:0] up_src, up_dst, dn_src, dn_dst, rx_src, rx_dst;
  logic [7:0] tx_data, rx_data;
  logic line_tx_req, line_rx_valid, tx_ready, rx_valid, rx_last, rx_ready;
  logic [19:0] rx_bits, tx_bits_a, tx_bits_b;
  logic rx_for_unit, rx_bcast, rx_is_req, rx_is_rsp, rx_frame_err, rx_locked;
  int err_count, checks, n_err, full_seen, e_err;
  logic [31:0] seed, seed2;
  logic [7:0] r;
  logic [16:0] got[$], exp[$];
  logic [7:0] msg[$], f[$];

  mcf_framer mcf_framer_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .line_side(line_side), .up_src(up_src), .up_dst(up_dst),
    .dn_src(dn_src), .dn_dst(dn_dst), .dual_loop_en(dual_loop_en),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .line_tx_req(line_tx_req), .tx_bits_a(tx_bits_a),
    .tx_bits_b(tx_bits_b), .line_rx_valid(line_rx_valid), .rx_bits(rx_bits),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_ready(rx_ready), .rx_src(rx_src), .rx_dst(rx_dst),
    .rx_for_unit(rx_for_unit), .rx_bcast(rx_bcast), .rx_is_req(rx_is_req),
    .rx_is_rsp(rx_is_rsp), .rx_frame_err(rx_frame_err),
    .rx_locked(rx_locked));
  mcf_peer mcf_peer_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .line_tx_req(line_tx_req), .line_rx_valid(line_rx_valid),
    .rx_bits(rx_bits), .tx_bits_a(tx_bits_a));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] rnd(ref logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction

  function automatic logic [15:0] crc(logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) for (int b = 0; b < 8; b++) begin
      c = (c[0] ^ q[i][b]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return c;
  endfunction

  task check(string what, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", what, e, s);
      err_count++;
    end
  endtask

  task summarize();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task rnd_msg(int n);
    r = rnd(seed);
    msg = {r[0] ? r % 8'd65 : 8'h80 + r % 8'd65};
    repeat (n) msg.push_back(rnd(seed));
  endtask

  // Valid stays up after the last octet so messages can follow back to back
  task feed();
    foreach (msg[i]) begin
      tx_valid = 1'b1;
      tx_data = msg[i];
      tx_last = (i == msg.size() - 1);
      while (!tx_ready) begin
        @(posedge clk_sys);
        #1;
      end
      @(posedge clk_sys);
      #1;
    end
  endtask

  // A probe case skips the frame queued just ahead of the probe
  task tx_case(bit probe);
    logic [7:0] o;
    int s, n;
    bit esc, done, skip;
    f = {};
    s = 0;
    esc = 0;
    done = 0;
    skip = probe;
    n = msg.size() > 72 ? 72 : msg.size();
    feed();
    tx_valid = 1'b0;
    for (int i = 0; i < 20000 && !done; i++) begin
      @(posedge clk_sys);
      while (mcf_peer_inst.rxq.size() > 0 && !done) begin
        o = mcf_peer_inst.rxq.pop_front();
        if (o == 8'h7E) begin
          if (f.size() > 0 && skip) begin
            skip = 0;
            f = {};
            s = 0;
          end else if (f.size() > 0) done = 1;
          else s++;
        end else if (esc) begin
          f.push_back(o ^ 8'h20);
          esc = 0;
        end else if (o == 8'h7D) esc = 1;
        else f.push_back(o);
      end
    end
    #1;
    if (probe) check("probe syncs", 1, s + 1 >= 5);
    check("frame length", n + 3, f.size());
    check("address octet", line_side ? {dn_src, dn_dst} : {up_src, up_dst},
      f[0]);
    for (int i = 0; i < n; i++) check("message octet", msg[i], f[i+1]);
    check("check residue", 16'hF0B8, crc(f));
  endtask

  // Mode 0 good, 1 corrupt check, 2 dropped with sound check
  task rx_frame(int mode);
    logic [15:0] c;
    c = ~crc(f);
    if (mode == 0) for (int i = 1; i < f.size(); i++) begin
      exp.push_back({i == f.size() - 1, f[0], f[i]});
    end
    e_err += (mode != 0);
    f.push_back(c[7:0]);
    f.push_back(mode == 1 ? ~c[15:8] : c[15:8]);
    repeat (5) mcf_peer_inst.txq.push_back(8'h7E);
    foreach (f[i]) if (f[i] == 8'h7E || f[i] == 8'h7D) begin
      mcf_peer_inst.txq.push_back(8'h7D);
      mcf_peer_inst.txq.push_back(f[i] ^ 8'h20);
    end else mcf_peer_inst.txq.push_back(f[i]);
    mcf_peer_inst.txq.push_back(8'h7E);
  endtask

  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1 && rx_ready) got.push_back({rx_last, rx_src,
      rx_dst, rx_data});
    if (rx_frame_err === 1'b1) n_err++;
    if (arst_n && tx_ready !== 1'b1) full_seen++;
    #1 rx_ready = rnd(seed2) > 8'h50;
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    summarize();
  end

  initial begin
    seed = 32'h34cc_cdf2;
    seed2 = 32'h34cc_cdf2;
    {arst_n, line_side, dual_loop_en, tx_valid, tx_last, rx_ready} = '0;
    {up_src, up_dst, dn_src, dn_dst, tx_data} = 24'h31_4208;
    {err_count, checks, n_err, full_seen, e_err} = '0;
    repeat (10) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    msg = {8'h05, 8'h7E, 8'h7D, 8'h7E, 8'h7D, 8'h00};
    tx_case(0);
    for (int j = 0; j < 6; j++) begin
      {dual_loop_en, line_side} = j[1:0];
      rnd_msg(rnd(seed) % 8'd9);
      tx_case(0);
    end
    msg = {8'h0B, 8'h00};
    feed();
    msg = {8'h01, 8'h00};
    tx_case(1);
    full_seen = 0;
    rnd_msg(79);
    tx_case(0);
    check("buffer refused", 1, full_seen > 0);
    for (int j = 0; j < 8; j++) begin
      r = rnd(seed);
      f = {{4'h1 + r[2:0], r[7] ? 4'hF : r[6] ? 4'h0 : 4'h3}};
      rnd_msg(r[5:3]);
      f = {f, msg};
      rx_frame(0);
    end
    f = {8'h21, 8'h02};
    rx_frame(1);
    f = {8'h21};
    rx_frame(2);
    f = {8'hF2, 8'h02};
    rx_frame(2);
    f = {8'h1D, 8'h02};
    rx_frame(2);
    f = {8'h21};
    repeat (75) f.push_back(8'h00);
    rx_frame(2);
    mcf_peer_inst.txq = {mcf_peer_inst.txq, 8'h7E, 8'h21, 8'h7D, 8'h41,
      8'h02, 8'h7E};
    e_err++;
    f = {8'h20, 8'h81, 8'h7D};
    rx_frame(0);
    for (int i = 0; i < 20000 && mcf_peer_inst.txq.size() > 0; i++) begin
      @(posedge clk_sys);
    end
    repeat (200) @(posedge clk_sys);
    check("discarded frames", e_err, n_err);
    check("octet lock", 1, rx_locked);
    check("rx octet count", exp.size(), got.size());
    foreach (exp[i]) check("rx octet", exp[i], got[i]);
    summarize();
  end
endmodule // mcf_framer_test
